// File: iba_arbiter.sv
// Bank arbiter and banked ROM/RAM arrays for four requesters.
`timescale 1ns/1ps
`default_nettype none
`include "iba_regs.svh"

// Operation
// R1 - ROM is two 256-bit pages, each four independent 64-bit banks.
// R2 - RAM is one 256-bit page of eight independent 32-bit banks.
// R3 - Up to three of four requesters are served per cycle if conflict-free.
// R4 - Two processor data ports carry one 64-bit access per cycle each.
// R5 - Program cache port fetches a whole 256-bit line per access.
// R6 - One 32-bit port shared by data mover and host, one at a time.
// R7 - A cache fill conflicts only with data accesses to the same page.
// R8 - Accesses to other pages or other banks proceed in the same cycle.
// R9 - A line fill returns the full line two cycles after its grant.
// R10 - Conflicting requests are stalled and later completed without loss.
module iba_arbiter
  import iba_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  input  wire logic                  cpu0_req,
  input  wire logic                  cpu0_wr,
  input  wire logic [1:0]            cpu0_page,
  input  wire logic [`IBA_ROW_W-1:0] cpu0_row,
  input  wire logic [1:0]            cpu0_dword,
  input  wire logic [63:0]           cpu0_wdata,
  output logic                       cpu0_ready,
  output logic                       cpu0_rvalid,
  output logic [63:0]                cpu0_rdata,
  input  wire logic                  cpu1_req,
  input  wire logic                  cpu1_wr,
  input  wire logic [1:0]            cpu1_page,
  input  wire logic [`IBA_ROW_W-1:0] cpu1_row,
  input  wire logic [1:0]            cpu1_dword,
  input  wire logic [63:0]           cpu1_wdata,
  output logic                       cpu1_ready,
  output logic                       cpu1_rvalid,
  output logic [63:0]                cpu1_rdata,
  input  wire logic                  fill_req,
  input  wire logic [1:0]            fill_page,
  input  wire logic [`IBA_ROW_W-1:0] fill_row,
  output logic                       fill_ready,
  output logic                       fill_rvalid,
  output logic [`IBA_LINE_W-1:0]     fill_rdata,
  input  wire logic                  dma_req,
  input  wire logic                  dma_wr,
  input  wire logic [1:0]            dma_page,
  input  wire logic [`IBA_ROW_W-1:0] dma_row,
  input  wire logic [2:0]            dma_lane,
  input  wire logic [31:0]           dma_wdata,
  output logic                       dma_ready,
  output logic                       dma_rvalid,
  input  wire logic                  host_req,
  input  wire logic                  host_wr,
  input  wire logic [1:0]            host_page,
  input  wire logic [`IBA_ROW_W-1:0] host_row,
  input  wire logic [2:0]            host_lane,
  input  wire logic [31:0]           host_wdata,
  output logic                       host_ready,
  output logic                       host_rvalid,
  output logic [31:0]                periph_rdata,
  input  wire logic                  rom_load_en,
  input  wire logic                  rom_load_page,
  input  wire logic [`IBA_ROW_W-1:0] rom_load_row,
  input  wire logic [`IBA_LINE_W-1:0] rom_load_line
);

  // Lanes are 32-bit slices of a line; a ROM bank is an aligned lane pair.
  function automatic iba_lanes_type lane_mask(input logic [1:0] page,
                                              input logic [2:0] lane,
                                              input logic       wide,
                                              input logic       fill);
    iba_lanes_type m;
    m = '0;
    if (fill) begin
      m = `IBA_ALL_LANES; // see R7
    end else if (page != `IBA_PAGE_RAM || wide) begin
      m = `IBA_PAIR_LANES << {lane[2:1], 1'b0}; // see R1
    end else begin
      m = `IBA_ONE_LANE << lane; // see R2
    end
    return m;
  endfunction

  logic [`IBA_LINE_W-1:0] rom_mem [0:2*`IBA_ROWS-1]; // see R1
  logic [`IBA_LINE_W-1:0] ram_mem [0:`IBA_ROWS-1];   // see R2

  logic [1:0]            rr_q;
  iba_owner_type         owner_q;
  iba_owner_type         owner_d;
  logic                  fill_pend_q;
  logic [`IBA_LINE_W-1:0] fill_line_q;

  logic                  req   [0:`IBA_NPORT-1];
  logic                  wr    [0:`IBA_NPORT-1];
  logic [1:0]            page  [0:`IBA_NPORT-1];
  logic [`IBA_ROW_W-1:0] row   [0:`IBA_NPORT-1];
  logic [2:0]            lane  [0:`IBA_NPORT-1];
  logic [63:0]           wdata [0:`IBA_NPORT-1];
  logic [`IBA_LINE_W-1:0] line [0:`IBA_NPORT-1];
  logic                  gnt   [0:`IBA_NPORT-1];
  iba_lanes_type         busy  [0:3];
  iba_lanes_type         want;
  logic [1:0]            ngnt;
  logic [1:0]            p;

  // The shared port stays with its owner while that owner still requests.
  always_comb begin
    owner_d = owner_q;
    if (owner_q == IBA_OWN_DMA && !dma_req && host_req) begin
      owner_d = IBA_OWN_HOST;
    end else if (owner_q == IBA_OWN_HOST && !host_req && dma_req) begin
      owner_d = IBA_OWN_DMA;
    end
  end

  always_comb begin
    req[`IBA_P_CPU0]   = cpu0_req; // see R4
    wr[`IBA_P_CPU0]    = cpu0_wr;
    page[`IBA_P_CPU0]  = cpu0_page;
    row[`IBA_P_CPU0]   = cpu0_row;
    lane[`IBA_P_CPU0]  = {cpu0_dword, 1'b0};
    wdata[`IBA_P_CPU0] = cpu0_wdata;
    req[`IBA_P_CPU1]   = cpu1_req; // see R4
    wr[`IBA_P_CPU1]    = cpu1_wr;
    page[`IBA_P_CPU1]  = cpu1_page;
    row[`IBA_P_CPU1]   = cpu1_row;
    lane[`IBA_P_CPU1]  = {cpu1_dword, 1'b0};
    wdata[`IBA_P_CPU1] = cpu1_wdata;
    req[`IBA_P_FILL]   = fill_req; // see R5
    wr[`IBA_P_FILL]    = 1'b0;
    page[`IBA_P_FILL]  = fill_page;
    row[`IBA_P_FILL]   = fill_row;
    lane[`IBA_P_FILL]  = '0;
    wdata[`IBA_P_FILL] = '0;
    if (owner_d == IBA_OWN_HOST) begin // see R6
      req[`IBA_P_PERIPH]   = host_req;
      wr[`IBA_P_PERIPH]    = host_wr;
      page[`IBA_P_PERIPH]  = host_page;
      row[`IBA_P_PERIPH]   = host_row;
      lane[`IBA_P_PERIPH]  = host_lane;
      wdata[`IBA_P_PERIPH] = {32'h0, host_wdata};
    end else begin
      req[`IBA_P_PERIPH]   = dma_req;
      wr[`IBA_P_PERIPH]    = dma_wr;
      page[`IBA_P_PERIPH]  = dma_page;
      row[`IBA_P_PERIPH]   = dma_row;
      lane[`IBA_P_PERIPH]  = dma_lane;
      wdata[`IBA_P_PERIPH] = {32'h0, dma_wdata};
    end
  end

  // Greedy grant in rotating order; the rotation bounds every stall except that of the shared port's non-owner.
  always_comb begin
    ngnt = '0;
    want = '0;
    p    = '0;
    for (int k = 0; k < 4; k++) begin
      busy[k] = '0;
    end
    for (int k = 0; k < `IBA_NPORT; k++) begin
      gnt[k] = 1'b0;
    end
    for (int k = 0; k < `IBA_NPORT; k++) begin
      p    = rr_q + k[1:0];
      want = lane_mask(page[p], lane[p], p != `IBA_P_PERIPH,
                       p == `IBA_P_FILL);
      if (ce && req[p] && ngnt != `IBA_MAXGNT && // see R3
          (busy[page[p]] & want) == '0) begin // see R8
        gnt[p]        = 1'b1;
        busy[page[p]] = busy[page[p]] | want;
        ngnt          = ngnt + 2'h1;
      end
    end
  end

  always_comb begin
    for (int k = 0; k < `IBA_NPORT; k++) begin
      unique case (page[k])
        `IBA_PAGE_ROM0: line[k] = rom_mem[{1'b0, row[k]}];
        `IBA_PAGE_ROM1: line[k] = rom_mem[{1'b1, row[k]}];
        `IBA_PAGE_RAM:  line[k] = ram_mem[row[k]];
        default:        line[k] = '0;
      endcase
    end
  end

  // A stalled requester holds its request; ready low means not yet taken.
  assign cpu0_ready = gnt[`IBA_P_CPU0]; // see R10
  assign cpu1_ready = gnt[`IBA_P_CPU1]; // see R10
  assign fill_ready = gnt[`IBA_P_FILL]; // see R10
  assign dma_ready  = gnt[`IBA_P_PERIPH] && owner_d == IBA_OWN_DMA;
  assign host_ready = gnt[`IBA_P_PERIPH] && owner_d == IBA_OWN_HOST;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rr_q    <= '0;
      owner_q <= IBA_OWN_DMA;
    end else if (ce) begin
      rr_q    <= rr_q + 2'h1; // see R10
      owner_q <= owner_d; // see R6
    end
  end

  // Only the RAM page takes writes; a write to ROM is granted and dropped.
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int k = 0; k < `IBA_NPORT; k++) begin
        if (gnt[k] && wr[k] && page[k] == `IBA_PAGE_RAM) begin
          if (k == `IBA_P_PERIPH) begin
            ram_mem[row[k]][{lane[k], 5'h0} +: 32] <= wdata[k][31:0];
          end else begin
            ram_mem[row[k]][{lane[k][2:1], 6'h0} +: 64] <= wdata[k];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && rom_load_en) begin
      rom_mem[{rom_load_page, rom_load_row}] <= rom_load_line;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu0_rvalid  <= 1'b0;
      cpu0_rdata   <= '0;
      cpu1_rvalid  <= 1'b0;
      cpu1_rdata   <= '0;
      dma_rvalid   <= 1'b0;
      host_rvalid  <= 1'b0;
      periph_rdata <= '0;
    end else if (ce) begin
      cpu0_rvalid <= gnt[`IBA_P_CPU0] && !wr[`IBA_P_CPU0];
      if (gnt[`IBA_P_CPU0] && !wr[`IBA_P_CPU0]) begin
        cpu0_rdata <= line[`IBA_P_CPU0][{cpu0_dword, 6'h0} +: 64];
      end
      cpu1_rvalid <= gnt[`IBA_P_CPU1] && !wr[`IBA_P_CPU1];
      if (gnt[`IBA_P_CPU1] && !wr[`IBA_P_CPU1]) begin
        cpu1_rdata <= line[`IBA_P_CPU1][{cpu1_dword, 6'h0} +: 64];
      end
      dma_rvalid  <= dma_ready && !dma_wr;
      host_rvalid <= host_ready && !host_wr;
      if (gnt[`IBA_P_PERIPH] && !wr[`IBA_P_PERIPH]) begin
        periph_rdata <=
          line[`IBA_P_PERIPH][{lane[`IBA_P_PERIPH], 5'h0} +: 32];
      end
    end
  end

  // Line fill pipeline: array read, then output stage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fill_pend_q <= 1'b0;
      fill_line_q <= '0;
      fill_rvalid <= 1'b0;
      fill_rdata  <= '0;
    end else if (ce) begin
      fill_pend_q <= gnt[`IBA_P_FILL];
      if (gnt[`IBA_P_FILL]) begin
        fill_line_q <= line[`IBA_P_FILL];
      end
      fill_rvalid <= fill_pend_q; // see R9
      if (fill_pend_q) begin
        fill_rdata <= fill_line_q; // see R9
      end
    end
  end

endmodule // iba_arbiter
`default_nettype wire

// File: iba_regs.svh
// Constants of the internal memory bank arbiter.
`ifndef IBA_REGS_SVH
`define IBA_REGS_SVH

`define IBA_NPORT      4
`define IBA_MAXGNT     2'h3
`define IBA_ROWS       16
`define IBA_ROW_W      4
`define IBA_LINE_W     256
`define IBA_PAGE_ROM0  2'h0
`define IBA_PAGE_ROM1  2'h1
`define IBA_PAGE_RAM   2'h2
`define IBA_P_CPU0     2'h0
`define IBA_P_CPU1     2'h1
`define IBA_P_FILL     2'h2
`define IBA_P_PERIPH   2'h3
`define IBA_ALL_LANES  8'hFF
`define IBA_PAIR_LANES 8'h03
`define IBA_ONE_LANE   8'h01

`endif

// File: iba_pkg.sv
// Types of the internal memory bank arbiter.
`default_nettype none
package iba_pkg;
  typedef logic [7:0] iba_lanes_type;
  typedef enum logic {IBA_OWN_DMA, IBA_OWN_HOST} iba_owner_type;
endpackage
`default_nettype wire

// File: iba_arbiter_assertions.sv
// Checker of grants and answer timing of the bank arbiter.
`timescale 1ns/1ps
`default_nettype none
module iba_arbiter_assertions (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic       cpu0_req,
  input wire logic       cpu0_wr,
  input wire logic       cpu0_ready,
  input wire logic       cpu0_rvalid,
  input wire logic       cpu1_ready,
  input wire logic       fill_req,
  input wire logic       fill_ready,
  input wire logic       fill_rvalid,
  input wire logic       dma_ready,
  input wire logic       host_ready,
  input wire logic [1:0] cpu0_page,
  input wire logic [1:0] cpu1_page,
  input wire logic [1:0] cpu0_dword,
  input wire logic [1:0] cpu1_dword,
  input wire logic [1:0] fill_page
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // The fill pipeline only advances on enabled cycles.
  sequence s_fill_take; fill_req && fill_ready ##1 ce; endsequence
  sequence s_line_back; ##1 fill_rvalid; endsequence
  a_ce_gates_grant: assert property (
    !ce |-> !(cpu0_ready || cpu1_ready || fill_ready || dma_ready ||
    host_ready)) else $error("grant with ce low");
  a_three_max: assert property (
    $countones({cpu0_ready, cpu1_ready, fill_ready, dma_ready | host_ready})
    <= 3) else $error("over three grants");
  a_one_periph: assert property (
    !(dma_ready && host_ready)) else $error("shared port granted twice");
  a_fill_latency: assert property (
    s_fill_take |-> s_line_back) else $error("line late");
  a_fill_echo: assert property (
    fill_rvalid && $past(ce) && $past(ce, 2) |-> $past(fill_ready, 2))
    else $error("line without fill");
  a_read_latency: assert property (
    cpu0_ready && !cpu0_wr |=> cpu0_rvalid) else $error("read answer late");
  a_fill_page: assert property (
    fill_ready |-> !(cpu0_ready && cpu0_page == fill_page) &&
    !(cpu1_ready && cpu1_page == fill_page)) else $error("page clash");
  a_bank_free: assert property (
    cpu0_ready && cpu1_ready && cpu0_page == cpu1_page && cpu0_page != 2'h3
    |-> cpu0_dword != cpu1_dword) else $error("bank clash granted");
  a_stall_max: assert property (
    cpu0_req && !cpu0_ready && ce |-> ##[1:3] cpu0_ready)
    else $error("stall too long");
endmodule // iba_arbiter_assertions
bind iba_arbiter iba_arbiter_assertions i_chk (.clk, .nrst, .ce, .cpu0_req,
  .cpu0_wr, .cpu0_ready, .cpu0_rvalid, .cpu1_ready, .fill_req, .fill_ready,
  .fill_rvalid, .dma_ready, .host_ready, .cpu0_page, .cpu1_page,
  .cpu0_dword, .cpu1_dword, .fill_page);
`default_nettype wire

// File: iba_fill_model.sv
// Program cache model that requests line fills and keeps the answer.
`timescale 1ns/1ps
`default_nettype none
module iba_fill_model (
  input  wire logic         clk,
  input  wire logic         start,
  input  wire logic         fill_ready,
  input  wire logic         fill_rvalid,
  input  wire logic [1:0]   page,
  input  wire logic [3:0]   row,
  input  wire logic [255:0] fill_rdata,
  output var logic          fill_req = 1'h0,
  output var logic [1:0]    fill_page = 2'h3,
  output var logic [3:0]    fill_row = 4'h0,
  output var logic [255:0]  line
);
  always @(posedge clk) begin
    if (start) begin
      fill_req <= #1 1'h1;
      fill_page <= #1 page;
      fill_row <= #1 row;
    end else if (fill_req && fill_ready) begin
      fill_req <= #1 1'h0;
      fill_row <= #1 ~fill_row;
    end
    if (fill_rvalid) line <= fill_rdata;
  end
endmodule // iba_fill_model
`default_nettype wire

// File: test_internal_memory_bank_arbiter.sv
// Self-checking bench of the internal memory bank arbiter.
`timescale 1ns/1ps
`default_nettype none
module test_internal_memory_bank_arbiter;
  logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, go = 1'h0;
  logic cpu0_req = 1'h0, cpu0_wr = 1'h0, cpu1_req = 1'h0, cpu1_wr = 1'h0;
  logic dma_req = 1'h0, dma_wr = 1'h0, host_req = 1'h0, host_wr = 1'h0;
  logic rom_load_en = 1'h0, rom_load_page = 1'h0;
  logic [1:0] cpu0_page = 2'h0, cpu1_page = 2'h0, cpu0_dword = 2'h0;
  logic [1:0] cpu1_dword = 2'h0, dma_page = 2'h0, host_page = 2'h0;
  logic [3:0] cpu0_row = 4'h0, cpu1_row = 4'h0, dma_row = 4'h0;
  logic [3:0] host_row = 4'h0, rom_load_row = 4'h0, frow = 4'h0, fill_row;
  logic [1:0] fpage = 2'h0, fill_page;
  logic [2:0] dma_lane = 3'h0, host_lane = 3'h0;
  logic [63:0] cpu0_wdata = '0, cpu1_wdata = '0, cpu0_rdata, cpu1_rdata;
  logic [63:0] g0, g1;
  logic [31:0] dma_wdata = '0, host_wdata = '0, periph_rdata, gd;
  logic [255:0] rom_load_line = '0, fill_rdata, fline;
  logic cpu0_ready, cpu0_rvalid, cpu1_ready, cpu1_rvalid, fill_req, fill_ready;
  logic fill_rvalid, dma_ready, dma_rvalid, host_ready, host_rvalid;
  int miscompares = 0, total_checks = 0;
  iba_arbiter i_dut (.clk, .nrst, .ce, .cpu0_req, .cpu0_wr, .cpu0_page,
    .cpu0_row, .cpu0_dword, .cpu0_wdata, .cpu0_ready, .cpu0_rvalid,
    .cpu0_rdata, .cpu1_req, .cpu1_wr, .cpu1_page, .cpu1_row, .cpu1_dword,
    .cpu1_wdata, .cpu1_ready, .cpu1_rvalid, .cpu1_rdata, .fill_req,
    .fill_page, .fill_row, .fill_ready, .fill_rvalid, .fill_rdata, .dma_req,
    .dma_wr, .dma_page, .dma_row, .dma_lane, .dma_wdata, .dma_ready,
    .dma_rvalid, .host_req, .host_wr, .host_page, .host_row, .host_lane,
    .host_wdata, .host_ready, .host_rvalid, .periph_rdata, .rom_load_en,
    .rom_load_page, .rom_load_row, .rom_load_line);
  iba_fill_model i_cache (.clk(clk), .start(go), .fill_ready(fill_ready),
    .fill_rvalid(fill_rvalid), .page(fpage), .row(frow),
    .fill_rdata(fill_rdata), .fill_req(fill_req), .fill_page(fill_page),
    .fill_row(fill_row), .line(fline));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (go) go <= #1 1'h0;
    if (cpu0_ready) cpu0_req <= #1 1'h0;
    if (cpu1_ready) cpu1_req <= #1 1'h0;
    if (dma_ready) dma_req <= #1 1'h0;
    if (host_ready) host_req <= #1 1'h0;
    if (cpu0_rvalid) g0 <= cpu0_rdata;
    if (cpu1_rvalid) g1 <= cpu1_rdata;
    if (dma_rvalid || host_rvalid) gd <= periph_rdata;
  end
  function automatic logic [255:0] ln(input logic [3:0] p, r);
    for (int i = 0; i < 8; i++) ln[i*32+:32] = {20'hA5A5A, p, r, 4'(i)};
  endfunction
  task automatic chk(input logic [255:0] g, e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Waits until every request is taken, then lets the answers land.
  task automatic settle;
    int n;
    n = 0;
    while ((go | fill_req | cpu0_req | cpu1_req | dma_req | host_req)
           && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      miscompares++;
      give_verdict;
    end else begin
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task automatic c0(input logic [1:0] p, d, input logic [3:0] r);
    cpu0_req = 1'h1;
    cpu0_page = p;
    cpu0_dword = d;
    cpu0_row = r;
  endtask
  task automatic c1(input logic [1:0] p, d, input logic [3:0] r);
    cpu1_req = 1'h1;
    cpu1_page = p;
    cpu1_dword = d;
    cpu1_row = r;
  endtask
  task automatic pd(input logic h, w, input logic [1:0] p,
                    input logic [3:0] r, input logic [2:0] l,
                    input logic [31:0] v);
    if (h) begin
      {host_req, host_wr, host_page, host_row, host_lane} = {1'h1, w, p, r, l};
      host_wdata = v;
    end else begin
      {dma_req, dma_wr, dma_page, dma_row, dma_lane} = {1'h1, w, p, r, l};
      dma_wdata = v;
    end
  endtask
  task automatic fl(input logic [1:0] p, input logic [3:0] r);
    go = 1'h1;
    fpage = p;
    frow = r;
  endtask
  task automatic t_parallel;
    {rom_load_en, rom_load_row, rom_load_line} = {1'h1, 4'h1, ln(4'h0, 4'h1)};
    @(posedge clk);
    #1;
    {rom_load_page, rom_load_row} = {1'h1, 4'h2};
    rom_load_line = ln(4'h1, 4'h2);
    fl(2'h1, 4'h2);
    @(posedge clk);
    #1;
    rom_load_en = 1'h0;
    c0(2'h0, 2'h2, 4'h1);
    pd(1'h0, 1'h0, 2'h2, 4'h0, 3'h0, '0);
    @(negedge clk);
    chk({cpu0_ready, fill_ready, dma_ready}, 3'h7);
    settle;
    chk(g0, 64'(ln(4'h0, 4'h1) >> 128));
    chk(fline, ln(4'h1, 4'h2));
  endtask
  task automatic t_shared;
    pd(1'h0, 1'h1, 2'h2, 4'h3, 3'h5, 32'h1111_5555);
    pd(1'h1, 1'h1, 2'h2, 4'h3, 3'h6, 32'h2222_6666);
    @(negedge clk);
    chk(dma_ready ^ host_ready, 1'h1);
    settle;
    c0(2'h2, 2'h2, 4'h3);
    c1(2'h2, 2'h3, 4'h3);
    pd(1'h0, 1'h0, 2'h2, 4'h3, 3'h5, '0);
    settle;
    chk(g0[63:32], 32'h1111_5555);
    chk(g1[31:0], 32'h2222_6666);
    chk(gd, 32'h1111_5555);
  endtask
  task automatic t_clash;
    fl(2'h0, 4'h1);
    @(posedge clk);
    #1;
    c0(2'h0, 2'h2, 4'h1);
    c1(2'h0, 2'h2, 4'h1);
    pd(1'h1, 1'h0, 2'h0, 4'h1, 3'h3, '0);
    settle;
    chk(g0, 64'(ln(4'h0, 4'h1) >> 128));
    chk(g1, 64'(ln(4'h0, 4'h1) >> 128));
    chk(gd, 32'(ln(4'h0, 4'h1) >> 96));
    chk(fline, ln(4'h0, 4'h1));
  endtask
  task automatic t_ce;
    ce = 1'h0;
    c0(2'h1, 2'h0, 4'h2);
    @(negedge clk);
    chk(cpu0_ready, 1'h0);
    @(posedge clk);
    #1;
    ce = 1'h1;
    settle;
    chk(g0, 64'(ln(4'h1, 4'h2)));
    // A write to a ROM page is taken but must leave the line untouched.
    cpu0_wr = 1'h1;
    c0(2'h1, 2'h0, 4'h2);
    settle;
    cpu0_wr = 1'h0;
    c1(2'h1, 2'h0, 4'h2);
    settle;
    chk(g1, 64'(ln(4'h1, 4'h2)));
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'h1;
    @(posedge clk);
    #1;
    t_parallel;
    t_shared;
    t_clash;
    t_ce;
    give_verdict;
  end
endmodule // test_internal_memory_bank_arbiter
`default_nettype wire
